// ---- design/lbs_bank_state.sv ----
// Per-bank command legality and state tracker for a low-power DDR memory
`timescale 1ns/1ps

module lbs_bank_state #(
    parameter int NBANK    = 8,
    parameter int BA_W     = 3,
    parameter int INIT_CNT = lbs_pkg::C_INIT
) (
    input  wire logic              CLK_SYS,
    input  wire logic              ARST_N,
    input  wire logic              CKE,
    input  wire logic              CMD_VALID,
    input  wire logic [3:0]        CMD_CODE,
    input  wire logic [BA_W-1:0]   CMD_BANK,
    input  wire logic              CMD_AP,
    output logic                   CMD_ILLEGAL,
    output logic [NBANK-1:0]       BANK_IDLE,
    output logic [NBANK-1:0]       BANK_BUSY,
    output logic                   DEV_RESETTING
);

    // ------------------------------------------------------------------
    // Input synchronisers and CKE history
    // ------------------------------------------------------------------
    logic [1:0]  cke_s_q;
    logic        cke_prev_q;
    logic        v_s1_q, v_s2_q, ap_s1_q, ap_s2_q;
    logic [3:0]  c_s1_q, c_s2_q;
    logic [BA_W-1:0] b_s1_q, b_s2_q;
    localparam int CNT_W_L = 16;
    logic [CNT_W_L-1:0] exit_q;

    // Command pins are asynchronous to this clock, so two flops each
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            v_s1_q  <= 1'b0;
            v_s2_q  <= 1'b0;
            ap_s1_q <= 1'b0;
            ap_s2_q <= 1'b0;
            c_s1_q  <= 4'h0;
            c_s2_q  <= 4'h0;
            b_s1_q  <= '0;
            b_s2_q  <= '0;
        end else begin
            v_s1_q  <= CMD_VALID;
            v_s2_q  <= v_s1_q;
            ap_s1_q <= CMD_AP;
            ap_s2_q <= ap_s1_q;
            c_s1_q  <= CMD_CODE;
            c_s2_q  <= c_s1_q;
            b_s1_q  <= CMD_BANK;
            b_s2_q  <= b_s1_q;
        end
    end

    // CKE history: current and previous sampled edge
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            cke_s_q    <= 2'h0;
            cke_prev_q <= 1'b0;
        end else begin
            cke_s_q    <= {cke_s_q[0], CKE};
            cke_prev_q <= cke_s_q[1];
        end
    end

    // Exit timer: any low CKE restarts it, commands wait until it drains
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            exit_q <= 16'h0000;
        end else if (!cke_s_q[1]) begin
            exit_q <= 16'(lbs_pkg::C_EXIT);
        end else if (exit_q != 16'h0000) begin
            exit_q <= exit_q - 16'h0001;
        end
    end

    logic cmd_ok;
    assign cmd_ok = v_s2_q && cke_s_q[1] && cke_prev_q && (exit_q == 16'h0000);

    // ------------------------------------------------------------------
    // Bank state and counters
    // ------------------------------------------------------------------
    lbs_pkg::lbs_state_e st_q [NBANK];
    logic [15:0]         cnt_q [NBANK];
    logic [BA_W-1:0]     last_bank_q;

    // Bank is in a state where nothing but NOP is legal
    function automatic logic is_locked(input lbs_pkg::lbs_state_e s);
        is_locked = (s == lbs_pkg::ST_REF_PB) || (s == lbs_pkg::ST_REF_AB)
                 || (s == lbs_pkg::ST_MRR_IDLE) || (s == lbs_pkg::ST_MRR_ACTIVE)
                 || (s == lbs_pkg::ST_MRR_RESET) || (s == lbs_pkg::ST_MR_WRITING)
                 || (s == lbs_pkg::ST_PRECH_ALL) || (s == lbs_pkg::ST_READ_AP)
                 || (s == lbs_pkg::ST_WRITE_AP);
    endfunction

    function automatic logic is_burst(input lbs_pkg::lbs_state_e s);
        is_burst = (s == lbs_pkg::ST_READING) || (s == lbs_pkg::ST_WRITING);
    endfunction

    function automatic logic is_ap(input lbs_pkg::lbs_state_e s);
        is_ap = (s == lbs_pkg::ST_READ_AP) || (s == lbs_pkg::ST_WRITE_AP);
    endfunction

    logic all_idle, any_locked, any_power_on, all_prechargeable, any_burst;
    always_comb begin
        all_idle          = 1'b1;
        any_locked        = 1'b0;
        any_burst         = 1'b0;
        any_power_on      = 1'b0;
        all_prechargeable = 1'b1;
        for (int i = 0; i < NBANK; i++) begin
            if (st_q[i] != lbs_pkg::ST_IDLE) all_idle = 1'b0;
            // Auto precharge bursts lock only their own bank, others stay open
            if (is_locked(st_q[i]) && !is_ap(st_q[i])) any_locked = 1'b1;
            if (is_burst(st_q[i]) || is_ap(st_q[i])) any_burst = 1'b1;
            if (st_q[i] == lbs_pkg::ST_POWER_ON || st_q[i] == lbs_pkg::ST_RESETTING)
                any_power_on = 1'b1;
            if (is_locked(st_q[i]) || st_q[i] == lbs_pkg::ST_RESETTING
                || st_q[i] == lbs_pkg::ST_POWER_ON) all_prechargeable = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Legality check for the command at hand
    // ------------------------------------------------------------------
    lbs_pkg::lbs_state_e tgt;
    logic                legal;
    assign tgt = st_q[b_s2_q];

    always_comb begin
        legal = 1'b0;
        if (any_locked) begin
            legal = 1'b0;
        end else begin
            case (c_s2_q)
                lbs_pkg::CMD_ACT:   legal = (tgt == lbs_pkg::ST_IDLE);
                lbs_pkg::CMD_RD,
                lbs_pkg::CMD_WR:    legal = (tgt == lbs_pkg::ST_ACTIVE) || is_burst(tgt);
                lbs_pkg::CMD_PRE:   legal = (tgt == lbs_pkg::ST_IDLE) || (tgt == lbs_pkg::ST_ACTIVE)
                                         || is_burst(tgt);
                lbs_pkg::CMD_PREA:  legal = all_prechargeable;
                lbs_pkg::CMD_REFPB: legal = (tgt == lbs_pkg::ST_IDLE);
                lbs_pkg::CMD_REFAB,
                lbs_pkg::CMD_MRW:   legal = all_idle;
                lbs_pkg::CMD_RESET: legal = all_idle || any_power_on;
                lbs_pkg::CMD_MRR:   legal = !any_burst;
                lbs_pkg::CMD_BST:   legal = is_burst(st_q[last_bank_q]);
                default:            legal = 1'b0;
            endcase
        end
    end

    // Flag illegal commands, registered so the output is a flop
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            CMD_ILLEGAL <= 1'b0;
        end else begin
            CMD_ILLEGAL <= cmd_ok && (c_s2_q != lbs_pkg::CMD_NOP) && !legal;
        end
    end

    // Bank that owns the most recent burst, for BST targeting
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            last_bank_q <= '0;
        end else if (cmd_ok && legal && (c_s2_q == lbs_pkg::CMD_RD || c_s2_q == lbs_pkg::CMD_WR)) begin
            last_bank_q <= b_s2_q;
        end
    end

    // ------------------------------------------------------------------
    // Per-bank state machines; illegal commands leave state untouched
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NBANK; g++) begin : g_bank
        logic hit;
        assign hit = cmd_ok && legal && (b_s2_q == BA_W'(g));
        always_ff @(posedge CLK_SYS or negedge ARST_N) begin
            if (!ARST_N) begin
                st_q[g]  <= lbs_pkg::ST_POWER_ON;
                cnt_q[g] <= 16'h0000;
            end else if (cmd_ok && legal && c_s2_q == lbs_pkg::CMD_REFAB) begin
                st_q[g]  <= lbs_pkg::ST_REF_AB;
                cnt_q[g] <= 16'(lbs_pkg::C_RFCAB);
            end else if (cmd_ok && legal && c_s2_q == lbs_pkg::CMD_MRW) begin
                st_q[g]  <= lbs_pkg::ST_MR_WRITING;
                cnt_q[g] <= 16'(lbs_pkg::T_MRW_CK);
            end else if (cmd_ok && legal && c_s2_q == lbs_pkg::CMD_RESET) begin
                st_q[g]  <= lbs_pkg::ST_RESETTING;
                cnt_q[g] <= 16'(INIT_CNT);
            end else if (cmd_ok && legal && c_s2_q == lbs_pkg::CMD_PREA) begin
                st_q[g]  <= lbs_pkg::ST_PRECH_ALL;
                cnt_q[g] <= 16'(lbs_pkg::C_RP);
            end else if (cmd_ok && legal && c_s2_q == lbs_pkg::CMD_MRR) begin
                // ST_ACTIVE, and ST_ACTIVATING in its last cycle, go to ST_MRR_ACTIVE; ST_RESETTING to ST_MRR_RESET; all else to ST_MRR_IDLE
                if (st_q[g] == lbs_pkg::ST_RESETTING) begin
                    st_q[g] <= lbs_pkg::ST_MRR_RESET;
                end else if (st_q[g] == lbs_pkg::ST_ACTIVE
                             || (st_q[g] == lbs_pkg::ST_ACTIVATING && cnt_q[g] <= 16'h0001)) begin
                    st_q[g] <= lbs_pkg::ST_MRR_ACTIVE;
                end else begin
                    st_q[g] <= lbs_pkg::ST_MRR_IDLE;
                end
                cnt_q[g] <= 16'(lbs_pkg::T_MRR_CK);
            end else if (cmd_ok && legal && c_s2_q == lbs_pkg::CMD_BST
                         && last_bank_q == BA_W'(g)) begin
                st_q[g]  <= lbs_pkg::ST_ACTIVE;
                cnt_q[g] <= 16'h0000;
            end else if (hit && c_s2_q == lbs_pkg::CMD_ACT) begin
                st_q[g]  <= lbs_pkg::ST_ACTIVATING;
                cnt_q[g] <= 16'(lbs_pkg::C_RCD);
            end else if (hit && (c_s2_q == lbs_pkg::CMD_RD || c_s2_q == lbs_pkg::CMD_WR)) begin
                // Auto precharge burst also covers the trailing tRP
                if (c_s2_q == lbs_pkg::CMD_RD)
                    st_q[g] <= ap_s2_q ? lbs_pkg::ST_READ_AP : lbs_pkg::ST_READING;
                else
                    st_q[g] <= ap_s2_q ? lbs_pkg::ST_WRITE_AP : lbs_pkg::ST_WRITING;
                cnt_q[g] <= ap_s2_q ? 16'(lbs_pkg::T_BURST_CK + lbs_pkg::C_RP)
                                    : 16'(lbs_pkg::T_BURST_CK);
            end else if (hit && c_s2_q == lbs_pkg::CMD_PRE) begin
                st_q[g]  <= lbs_pkg::ST_PRECHARGING;
                cnt_q[g] <= 16'(lbs_pkg::C_RP);
            end else if (hit && c_s2_q == lbs_pkg::CMD_REFPB) begin
                st_q[g]  <= lbs_pkg::ST_REF_PB;
                cnt_q[g] <= 16'(lbs_pkg::C_RFCPB);
            end else if (cnt_q[g] > 16'h0001) begin
                cnt_q[g] <= cnt_q[g] - 16'h0001;
            end else if (cnt_q[g] == 16'h0001) begin
                cnt_q[g] <= 16'h0000;
                case (st_q[g])
                    lbs_pkg::ST_ACTIVATING,
                    lbs_pkg::ST_MRR_ACTIVE,
                    lbs_pkg::ST_READING,
                    lbs_pkg::ST_WRITING:    st_q[g] <= lbs_pkg::ST_ACTIVE;
                    lbs_pkg::ST_MRR_RESET:  st_q[g] <= lbs_pkg::ST_RESETTING;
                    lbs_pkg::ST_RESETTING:  st_q[g] <= lbs_pkg::ST_IDLE;
                    default:                st_q[g] <= lbs_pkg::ST_IDLE;
                endcase
            end
        end

        // Status outputs, registered
        always_ff @(posedge CLK_SYS or negedge ARST_N) begin
            if (!ARST_N) begin
                BANK_IDLE[g] <= 1'b0;
                BANK_BUSY[g] <= 1'b0;
            end else begin
                BANK_IDLE[g] <= (st_q[g] == lbs_pkg::ST_IDLE);
                BANK_BUSY[g] <= is_locked(st_q[g]);
            end
        end
    end

    // Device-wide resetting indication
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            DEV_RESETTING <= 1'b0;
        end else begin
            DEV_RESETTING <= (st_q[0] == lbs_pkg::ST_RESETTING);
        end
    end

endmodule // lbs_bank_state

// ---- design/lbs_pkg.sv ----
// Package: command codes, bank states and timing constants for the bank state tracker
package lbs_pkg;

    // ------------------------------------------------------------------
    // Command codes presented on the decoded command port
    // ------------------------------------------------------------------
    localparam logic [3:0] CMD_NOP     = 4'h0;
    localparam logic [3:0] CMD_ACT     = 4'h1;
    localparam logic [3:0] CMD_RD      = 4'h2;
    localparam logic [3:0] CMD_WR      = 4'h3;
    localparam logic [3:0] CMD_PRE     = 4'h4;
    localparam logic [3:0] CMD_PREA    = 4'h5;
    localparam logic [3:0] CMD_REFPB   = 4'h6;
    localparam logic [3:0] CMD_REFAB   = 4'h7;
    localparam logic [3:0] CMD_MRR     = 4'h8;
    localparam logic [3:0] CMD_MRW     = 4'h9;
    localparam logic [3:0] CMD_RESET   = 4'ha;
    localparam logic [3:0] CMD_BST     = 4'hb;

    // ------------------------------------------------------------------
    // Bank states
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_POWER_ON, ST_RESETTING, ST_IDLE, ST_ACTIVATING, ST_ACTIVE,
        ST_READING, ST_WRITING, ST_READ_AP, ST_WRITE_AP, ST_PRECHARGING,
        ST_PRECH_ALL, ST_REF_PB, ST_REF_AB, ST_MRR_IDLE, ST_MRR_ACTIVE,
        ST_MRR_RESET, ST_MR_WRITING
    } lbs_state_e;

    // ------------------------------------------------------------------
    // Timing in nanoseconds and clock counts at 200 MHz
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int T_RP_NS       = 18;
    localparam int T_RCD_NS      = 18;
    localparam int T_RFCPB_NS    = 60;
    localparam int T_RFCAB_NS    = 130;
    localparam int T_MRR_CK      = 2;
    localparam int T_MRW_CK      = 5;
    localparam int T_BURST_CK    = 4;
    localparam int T_INIT_NS     = 1000;
    localparam int T_EXIT_NS     = 8;
    localparam int CNT_W         = 8;
    localparam int C_RP     = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int C_RCD    = (T_RCD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int C_RFCPB  = (T_RFCPB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int C_RFCAB  = (T_RFCAB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int C_INIT   = (T_INIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int C_EXIT   = (T_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// ---- bench/lbs_bank_state_checker.sv ----
// Checker: port-level properties of the bank state tracker
`timescale 1ns/1ps

module lbs_bank_state_checker #(
    parameter int NBANK    = 8,
    parameter int BA_W     = 3,
    parameter int INIT_CNT = 20
) (
    input logic             CLK_SYS,
    input logic             ARST_N,
    input logic             CKE,
    input logic             CMD_VALID,
    input logic [3:0]       CMD_CODE,
    input logic [BA_W-1:0]  CMD_BANK,
    input logic             CMD_AP,
    input logic             CMD_ILLEGAL,
    input logic [NBANK-1:0] BANK_IDLE,
    input logic [NBANK-1:0] BANK_BUSY,
    input logic             DEV_RESETTING
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!ARST_N);

    // Command of one code on the pins with CKE high; refusal shows three edges later,
    // status four, since the state flop sits in front of the status flop
    function automatic logic cmd_is(input logic [3:0] c);
        return CMD_VALID && CKE && CMD_CODE == c;
    endfunction

    // ----------
    // Properties
    // ----------
    property p_ill_cause;
        CMD_ILLEGAL |-> $past(CMD_VALID, 3) && $past(CKE, 3);
    endproperty
    a_ill_cause: assert property (p_ill_cause) else $error("refusal without command");
    property p_cke_low;
        CMD_VALID && !CKE |-> ##3 !CMD_ILLEGAL;
    endproperty
    a_cke_low: assert property (p_cke_low) else $error("command seen with CKE low");
    property p_act_open;
        cmd_is(lbs_pkg::CMD_ACT) && $past(CKE) && BANK_IDLE[CMD_BANK] && BANK_BUSY == '0
            |-> ##3 !CMD_ILLEGAL ##1 !BANK_IDLE[$past(CMD_BANK, 4)];
    endproperty
    a_act_open: assert property (p_act_open) else $error("activate not taken");
    property p_refpb_busy;
        cmd_is(lbs_pkg::CMD_REFPB) && $past(CKE) && BANK_IDLE == '1
            |-> ##4 BANK_BUSY == (NBANK'(1) << $past(CMD_BANK, 4));
    endproperty
    a_refpb_busy: assert property (p_refpb_busy) else $error("bank refresh mask");
    property p_refab_busy;
        cmd_is(lbs_pkg::CMD_REFAB) && $past(CKE) && BANK_IDLE == '1 |-> ##4 BANK_BUSY == '1;
    endproperty
    a_refab_busy: assert property (p_refab_busy) else $error("all-bank refresh");
    property p_mrw_refused;
        cmd_is(lbs_pkg::CMD_MRW) && $past(CKE) && BANK_IDLE != '1 && BANK_BUSY == '0
            |-> ##3 CMD_ILLEGAL;
    endproperty
    a_mrw_refused: assert property (p_mrw_refused) else $error("mode write not refused");
    property p_reset_go;
        cmd_is(lbs_pkg::CMD_RESET) && $past(CKE) && BANK_IDLE == '1 |-> ##4 DEV_RESETTING;
    endproperty
    a_reset_go: assert property (p_reset_go) else $error("reset from idle");
    property p_idle_busy;
        (BANK_IDLE & BANK_BUSY) == '0;
    endproperty
    a_idle_busy: assert property (p_idle_busy) else $error("bank idle and busy");
endmodule // lbs_bank_state_checker

bind lbs_bank_state lbs_bank_state_checker #(.NBANK(NBANK), .BA_W(BA_W), .INIT_CNT(INIT_CNT))
    lbs_bank_state_checker_inst (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .CKE(CKE),
    .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_BANK(CMD_BANK), .CMD_AP(CMD_AP),
    .CMD_ILLEGAL(CMD_ILLEGAL), .BANK_IDLE(BANK_IDLE), .BANK_BUSY(BANK_BUSY),
    .DEV_RESETTING(DEV_RESETTING));

// ---- bench/lbs_ctrl_model.sv ----
// Controller model: one command at a time on the decoded command port
`timescale 1ns/1ps

module lbs_ctrl_model (
    input  logic       CLK_SYS,
    input  logic [7:0] BANK_BUSY,
    output logic       CKE,
    output logic       CMD_VALID,
    output logic [3:0] CMD_CODE,
    output logic [2:0] CMD_BANK,
    output logic       CMD_AP
);
    // Bus rests empty with CKE high so the device may leave reset
    initial begin
        CKE       = 1'b1;
        CMD_VALID = 1'b0;
        CMD_CODE  = 4'h0;
        CMD_BANK  = 3'h0;
        CMD_AP    = 1'b0;
    end

    // CKE moves only off the sampling edge
    task automatic set_cke(input logic v);
        @(negedge CLK_SYS);
        CKE = v;
    endtask

    // Waits out NOP-only states, holds one command a cycle, then scrambles the
    // qualifiers so nothing can lean on stale values
    task automatic issue(input logic [3:0] c, input logic [2:0] bk, input logic ap,
                         input int post);
        int n;
        n = 0;
        while (BANK_BUSY != 8'h00 && n < 200) begin
            n++;
            @(negedge CLK_SYS);
        end
        @(negedge CLK_SYS);
        CMD_VALID = 1'b1;
        CMD_CODE  = c;
        CMD_BANK  = bk;
        CMD_AP    = ap;
        @(negedge CLK_SYS);
        CMD_VALID = 1'b0;
        CMD_CODE  = ~c;
        CMD_BANK  = ~bk;
        CMD_AP    = ~ap;
        repeat (post) @(negedge CLK_SYS); // Waits post cycles: status lags pins by four edges, refusal by three
    endtask
endmodule // lbs_ctrl_model

// ---- bench/lbs_bank_state_test.sv ----
// Testbench: bank state tracker driven through the controller model
`timescale 1ns/1ps

module lbs_bank_state_test;
    logic       clk_sys = 1'b0;
    logic       arst_n  = 1'b0;
    logic       cke, cmd_valid, cmd_ap, cmd_illegal, dev_resetting;
    logic       ill_seen;
    int         ill_cnt  = 0;
    int         ill_base = 0;
    logic [3:0] cmd_code;
    logic [2:0] cmd_bank;
    logic [7:0] bank_idle, bank_busy, mk;
    logic [3:0] codes [10];
    int         errors  = 0;
    int         checked = 0;
    int         seed    = 32'heb2b;
    int         b, m, n;

    lbs_bank_state #(.INIT_CNT(20)) lbs_bank_state_inst (
        .CLK_SYS(clk_sys), .ARST_N(arst_n), .CKE(cke), .CMD_VALID(cmd_valid),
        .CMD_CODE(cmd_code), .CMD_BANK(cmd_bank), .CMD_AP(cmd_ap),
        .CMD_ILLEGAL(cmd_illegal), .BANK_IDLE(bank_idle), .BANK_BUSY(bank_busy),
        .DEV_RESETTING(dev_resetting));
    lbs_ctrl_model lbs_ctrl_model_inst (
        .CLK_SYS(clk_sys), .BANK_BUSY(bank_busy), .CKE(cke), .CMD_VALID(cmd_valid),
        .CMD_CODE(cmd_code), .CMD_BANK(cmd_bank), .CMD_AP(cmd_ap));

    always #2.5 clk_sys = ~clk_sys;
    // Counts refusal pulses; one writer only, send marks where each command starts
    always @(posedge clk_sys) begin
        if (cmd_illegal === 1'b1) ill_cnt <= ill_cnt + 1;
    end
    assign ill_seen = (ill_cnt != ill_base);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t %s: got %0h want %0h", $time, what, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Length in cycles of each NOP-only state but the auto precharge bursts
    function automatic int exp_len(input logic [3:0] c);
        case (c)
            lbs_pkg::CMD_REFPB: return lbs_pkg::C_RFCPB;
            lbs_pkg::CMD_REFAB: return lbs_pkg::C_RFCAB;
            lbs_pkg::CMD_MRW:   return lbs_pkg::T_MRW_CK;
            lbs_pkg::CMD_MRR:   return lbs_pkg::T_MRR_CK;
            default:            return lbs_pkg::C_RP;
        endcase
    endfunction
    task automatic send(input logic [3:0] c, input int bk, input logic ap, input int post);
        ill_base = ill_cnt;
        lbs_ctrl_model_inst.issue(c, 3'(bk), ap, post);
    endtask
    function automatic logic hit(input logic busy_mode, input logic [7:0] k);
        return busy_mode ? bank_busy === k : (~bank_idle & k) === k;
    endfunction
    // Counts the cycles a busy pattern (or a not-idle pattern) holds
    task automatic measure(input logic busy_mode, input logic [7:0] k, output int len);
        len = 0;
        for (int w = 0; w < 20 && !hit(busy_mode, k); w++) @(negedge clk_sys);
        while (hit(busy_mode, k) && len < 300) begin
            len++;
            @(negedge clk_sys);
        end
    endtask
    task automatic wait_idle(input logic [7:0] k);
        for (int w = 0; w < 300 && (bank_idle & k) !== k; w++) @(negedge clk_sys);
    endtask

    // ----------
    // Stimulus
    // ----------
    initial begin
        codes = '{lbs_pkg::CMD_REFPB, lbs_pkg::CMD_REFAB, lbs_pkg::CMD_MRW, lbs_pkg::CMD_MRR,
                  lbs_pkg::CMD_PREA, lbs_pkg::CMD_REFPB, lbs_pkg::CMD_REFAB, lbs_pkg::CMD_MRW,
                  lbs_pkg::CMD_RESET, lbs_pkg::CMD_BST};
        repeat (5) @(negedge clk_sys);
        arst_n = 1'b1;
        @(negedge clk_sys);
        check(bank_idle, 8'h00, "power-on banks");
        send(lbs_pkg::CMD_ACT, 0, 1'b0, 3);
        check(ill_seen, 1'b1, "activate before init");
        send(lbs_pkg::CMD_RESET, 0, 1'b0, 3);
        check(dev_resetting, 1'b1, "init from power-on");
        wait_idle(8'hff);
        check({dev_resetting, bank_idle}, 9'h0ff, "init done");
        for (int i = 0; i < 5; i++) begin
            b = $random(seed) & 7;
            send(codes[i], b, 1'b0, 3);
            measure(1'b1, (codes[i] == lbs_pkg::CMD_REFPB) ? 8'h01 << b : 8'hff, n);
            check(n, exp_len(codes[i]), "nop-only span");
            check(bank_idle, 8'hff, "idle after span");
        end
        send(lbs_pkg::CMD_RESET, 0, 1'b0, 3);
        check(dev_resetting, 1'b1, "init from idle");
        wait_idle(8'hff);
        b = $random(seed) & 7;
        m = (b + 1 + ($random(seed) & 3)) & 7;
        mk = ~((8'h01 << b) | (8'h01 << m));
        send(lbs_pkg::CMD_ACT, b, 1'b0, 0); // Second activate lands while b is opening
        send(lbs_pkg::CMD_ACT, m, 1'b0, lbs_pkg::C_RCD + 2);
        check({bank_busy, bank_idle}, {8'h00, mk}, "two rows open");
        for (int i = 5; i < 10; i++) begin
            send(codes[i], b, 1'b0, 3 + ($random(seed) & 3));
            check(ill_seen, 1'b1, "refused");
            check(bank_idle, mk, "refusal keeps state");
        end
        send(lbs_pkg::CMD_MRR, m, 1'b0, 3);
        measure(1'b1, 8'hff, n);
        check(n, lbs_pkg::T_MRR_CK, "register read span");
        check(bank_idle, mk, "rows still open");
        send(lbs_pkg::CMD_RD, b, 1'b0, 0);
        send(lbs_pkg::CMD_BST, m, 1'b0, 3); // Aimed at m, yet stops the burst on b
        check(ill_seen, 1'b0, "stop latest burst");
        send(lbs_pkg::CMD_WR, b, 1'b0, 6); // Write burst ends before the next read
        check(ill_seen, 1'b0, "write after stop");
        send(lbs_pkg::CMD_RD, m, 1'b1, 3);
        wait_idle(8'h01 << m);
        check(bank_idle[m], 1'b1, "auto precharge closes row");
        send(lbs_pkg::CMD_PRE, b, 1'b0, 3);
        wait_idle(8'hff);
        check(bank_idle, 8'hff, "row closed");
        send(lbs_pkg::CMD_PRE, b, 1'b0, 3);
        measure(1'b0, 8'h01 << b, n);
        check(n, lbs_pkg::C_RP, "precharge of idle bank");
        lbs_ctrl_model_inst.set_cke(1'b0);
        send(lbs_pkg::CMD_ACT, b, 1'b0, 3);
        check({ill_seen, bank_idle}, 9'h0ff, "ignored with CKE low");
        lbs_ctrl_model_inst.set_cke(1'b1);
        repeat (10) @(negedge clk_sys);
        mk = ~(8'h01 << b);
        send(lbs_pkg::CMD_ACT, b, 1'b0, 3);
        check(bank_idle, mk, "taken after CKE high");
        finish_test();
    end

    // The run needs under 2000 cycles; ten times that means a hang
    initial begin
        #100000;
        errors++;
        finish_test();
    end
endmodule // lbs_bank_state_test
